// File: dv/afe_link_assertions.sv
// checker for the pins between the controller end and the front end
module afe_link_assertions (
   input wire logic I_CORE_CLK,
   input wire logic I_RSTN,
   input wire logic serial_select,
   input wire logic serial_clock,
   input wire logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic front_end_enable_pin,
   input wire logic front_end_ready_pin,
   input wire logic conversion_trigger_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   import afe_pkg::*;
   logic [7:0] gap_q;
   logic       trig_q;
   // ==========================================================
   // cycles since the last trigger rise, saturating so idle time never wraps
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         gap_q  <= 8'hff;
         trig_q <= 1'b0;
      end else begin
         trig_q <= conversion_trigger_pin;
         gap_q  <= (conversion_trigger_pin && !trig_q) ? 8'h01 : gap_q + {7'h0, gap_q != 8'hff};
      end
   end
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RSTN);
   // ==========================================================
   // properties
   a_sdo_idle_low: assert property (!serial_select [*5] |-> !serial_data_out)
      else $error("data out not low while deselected");
   a_sleep_not_ready: assert property (!front_end_enable_pin [*5] |-> !front_end_ready_pin)
      else $error("ready high while asleep");
   a_wake_bound: assert property ($rose(front_end_enable_pin) |->
      ##[1:500] (front_end_ready_pin || !front_end_enable_pin))
      else $error("ready late after enable");
   a_trig_after_ready: assert property ($rose(conversion_trigger_pin) |->
      front_end_ready_pin && front_end_enable_pin)
      else $error("trigger before ready");
   a_trig_high_min: assert property ($rose(conversion_trigger_pin) |-> conversion_trigger_pin [*8])
      else $error("trigger pulse too short");
   a_trig_spacing: assert property ($rose(conversion_trigger_pin) |-> gap_q >= TRIG_SPACE_CYC)
      else $error("trigger edges too close");
   a_drop_after_conv: assert property ($fell(front_end_enable_pin) |->
      gap_q >= HOLD_CYC + SYNC_CYC)
      else $error("enable dropped too soon");
   a_quiet_enabled: assert property (front_end_enable_pin |-> !serial_select)
      else $error("serial traffic while enabled");
   a_sclk_idle_low: assert property (!serial_select |-> !serial_clock)
      else $error("serial clock outside frame");
   a_select_lead: assert property ($rose(serial_select) |-> !serial_clock [*8])
      else $error("select lead too short");
   a_sclk_high_phase: assert property ($rose(serial_clock) |-> serial_clock [*8] ##1 !serial_clock)
      else $error("clock high phase wrong");
   a_din_stable_high: assert property (serial_clock |-> $stable(serial_data_in))
      else $error("data in moved while clock high");
endmodule

// File: dv/testbench.sv
// self-checking bench: controller end and front end joined over the link
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import afe_pkg::*;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [7:0] rdata;
   logic [9:0] adc = 10'h000;
   logic       pd;
   logic [2:0] mux;
   logic       sleep;
   logic       conv;
   logic [7:0] bf [8] = '{default: 8'h00};
   logic [31:0] seed = 32'h5bda5cf1;
   int         fails = 0;
   int         compares = 0;
   afe_link_if link ();
   afe_host u_afe_host (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .LINK(link));
   afe_device u_afe_device (.I_CORE_CLK(clk), .I_RSTN(rstn), .LINK(link), .I_ADC_RESULT(adc),
      .O_PD_SELECT(pd), .O_MUX_SELECT(mux), .O_SLEEP(sleep), .O_CONVERTING(conv));
   afe_link_assertions u_afe_link_assertions (.I_CORE_CLK(clk), .I_RSTN(rstn),
      .serial_select(link.serial_select), .serial_clock(link.serial_clock),
      .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
      .front_end_enable_pin(link.front_end_enable_pin),
      .front_end_ready_pin(link.front_end_ready_pin),
      .conversion_trigger_pin(link.conversion_trigger_pin));
   initial begin
      forever #50 clk = ~clk;
   end
   // ==========================================================
   // helpers
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic poll(input int b, input logic v);
      logic [7:0] st;
      int n;
      n = 0;
      do begin
         rd(HREG_CTRL, st);
         n++;
      end while (st[b] !== v && n < 2000);
      chk("status bit", {7'h0, v}, {7'h0, st[b]});
   endtask
   // one serial frame of n data bytes through the controller's buffer
   task automatic xfer(input logic dir, input logic ai, input logic [5:0] ra, input int n);
      wr(HREG_HEADER, {dir, ra[5:2], ai, ra[1:0]});
      wr(HREG_LEN, 8'(n - 1));
      for (int k = 0; k < n; k++) wr(4'h8 + 4'(k), bf[k]);
      wr(HREG_CTRL, 8'h01);
      poll(HST_BUSY_BIT, 1'b0);
      for (int k = 0; k < n; k++) rd(4'h8 + 4'(k), bf[k]);
   endtask
   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #6000000;
      fails++;
      complete_run();
   end
   // ==========================================================
   // main sequence
   initial begin
      logic [7:0] sel [4];
      logic [9:0] res [8];
      logic [3:0] e;
      logic [2:0] k;
      int t;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      xfer(1'b1, 1'b1, REG_ADC_CFG, 2);
      chk("cfg reset", CFG_RESET, bf[0]);
      chk("sample reset", SAMPLE_RESET, bf[1]);
      for (int i = 0; i < 4; i++) begin
         sel[i] = 8'(rnd());
         bf[i]  = sel[i];
      end
      xfer(1'b0, 1'b1, REG_SAMPLE_BASE, 4);
      bf[0] = ~sel[0];
      bf[1] = ~sel[1];
      sel[0] = ~sel[0];
      xfer(1'b0, 1'b0, REG_SAMPLE_BASE, 2);
      xfer(1'b1, 1'b1, REG_SAMPLE_BASE, 5);
      for (int i = 0; i < 4; i++) chk("sample reg", sel[i], bf[i]);
      chk("empty slot", 8'h00, bf[4]);
      wr(HREG_CTRL, 8'h02);
      poll(HST_READY_BIT, 1'b1);
      for (int i = 0; i <= 9; i++) begin
         k = 3'(i);
         e = k[0] ? sel[k[2:1]][7:4] : sel[k[2:1]][3:0];
         chk("mux", {5'h0, e[2:0]}, {5'h0, mux});
         chk("pd", {7'h0, e[3]}, {7'h0, pd});
         if (i < 9) begin
            res[k] = 10'(rnd());
            @(posedge clk) adc <= res[k];
            wr(HREG_CTRL, 8'h06);
            poll(HST_TRIG_BIT, 1'b0);
            t = 0;
            while (conv !== 1'b0 && t < 200) begin
               @(posedge clk);
               #1 t++;
            end
            repeat (2) @(posedge clk);
            #1;
            chk("conv end", 8'h00, {7'h0, conv});
            chk("awake", 8'h00, {7'h0, sleep});
         end
      end
      // the controller refuses to drop enable until its hold time has run out
      repeat (DROP_CYC + SYNC_CYC) @(posedge clk);
      wr(HREG_CTRL, 8'h00);
      poll(HST_ENABLE_BIT, 1'b0);
      repeat (6) @(posedge clk);
      #1 chk("sleep", 8'h01, {7'h0, sleep});
      xfer(1'b1, 1'b0, REG_STATUS, 1);
      chk("done", 8'h01, {7'h0, bf[0][STAT_DONE_BIT]});
      for (int h = 0; h < 2; h++) begin
         xfer(1'b1, 1'b1, REG_RESULT_BASE + 6'(8 * h), 8);
         for (int j = 0; j < 4; j++) begin
            chk("res hi", res[4 * h + j][9:2], bf[2 * j]);
            chk("res lo", {6'h0, res[4 * h + j][1:0]}, bf[2 * j + 1]);
         end
      end
      wr(HREG_CTRL, 8'h02);
      poll(HST_ENABLE_BIT, 1'b1);
      repeat (10) @(posedge clk);
      wr(HREG_CTRL, 8'h00);
      poll(HST_ENABLE_BIT, 1'b0);
      xfer(1'b1, 1'b1, REG_RESULT_BASE, 2);
      chk("cleared hi", 8'h00, bf[0]);
      chk("cleared lo", 8'h00, bf[1]);
      // converter disabled before the enable rise: a trigger must start nothing
      bf[0] = 8'h00;
      xfer(1'b0, 1'b0, REG_ADC_CFG, 1);
      wr(HREG_CTRL, 8'h02);
      poll(HST_READY_BIT, 1'b1);
      wr(HREG_CTRL, 8'h06);
      repeat (20) @(posedge clk);
      #1 chk("conv off", 8'h00, {7'h0, conv});
      poll(HST_TRIG_BIT, 1'b0);
      repeat (DROP_CYC + SYNC_CYC) @(posedge clk);
      wr(HREG_CTRL, 8'h00);
      poll(HST_ENABLE_BIT, 1'b0);
      complete_run();
   end
endmodule

// File: rtl/afe_device.sv
// front end: serial register port and conversion sequencer with result memory
// ==========================================================
// How it works
// - controller enables converter before raising enable
// - ready rises within 50 us of enable
// - conversion starts on trigger rising edge only
// - controller spaces trigger edges 10 us apart
// - 3-bit sample counter, clear while disabled, wraps
// - selection field k applies after k samples
// - eight result slots cleared at enable rise
// - n-th result into slot n-1, wraps
// - done flag set at conversion end
// - sleep while enable pin is low
// - controller waits 1 us before dropping enable
// - controller keeps emitter on 1 us
// - four-wire port: select, clock, data in/out
// - controller avoids serial traffic while enabled
// - header: direction, auto-increment, 6-bit address
// - write commits whole byte, then address advances
// - no auto-increment: one byte, then idle
// - partial byte at select fall is dropped
// - read shifts out register, address advances
// - output low while select low
// - controller keeps serial clock and select timing
// - results read as pairs from 0x10
// - selection fields in registers 0x0c to 0x0f
module afe_device (
   input  wire logic                          I_CORE_CLK,
   input  wire logic                          I_RSTN,
   afe_link_if.dev                            LINK,
   input  wire logic [afe_pkg::RESULT_W-1:0]  I_ADC_RESULT,
   output logic                               O_PD_SELECT,
   output logic [2:0]                         O_MUX_SELECT,
   output logic                               O_SLEEP,
   output logic                               O_CONVERTING
);
   import afe_pkg::*;

   // value is arbitrary
   localparam logic [7:0] ID_CODE = 8'h5a;

   // ==========================================================
   // pin synchronisers
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   logic [4:0] pin_prev_q;
   wire  [4:0] pin_raw = {LINK.conversion_trigger_pin, LINK.front_end_enable_pin,
                          LINK.serial_data_in, LINK.serial_clock, LINK.serial_select};

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pin_s1_q   <= 5'h00;
         pin_s2_q   <= 5'h00;
         pin_prev_q <= 5'h00;
      end else begin
         pin_s1_q   <= pin_raw;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   wire sel_w      = pin_s2_q[0];
   wire sclk_rise  = pin_s2_q[1] & ~pin_prev_q[1];
   wire sclk_fall  = ~pin_s2_q[1] & pin_prev_q[1];
   wire sdi_w      = pin_s2_q[2];
   wire en_w       = pin_s2_q[3];
   wire en_rise    = pin_s2_q[3] & ~pin_prev_q[3];
   wire trig_rise  = pin_s2_q[4] & ~pin_prev_q[4];

   // ==========================================================
   // storage
   logic [7:0]          cfg_q;
   logic [7:0]          samp_q [4];
   logic [RESULT_W-1:0] res_q  [8];
   logic                done_q;
   logic                ready_q;
   logic                busy_q;
   logic                conv_on_q;
   logic [2:0]          cnt_q;
   logic [WAKE_CNT_W-1:0] wake_q;
   logic [CONV_CNT_W-1:0] conv_cnt_q;

   function automatic logic [7:0] rd_byte(input logic [5:0] a);
      logic [2:0] slot;
      slot    = a[3:1];
      rd_byte = 8'h00;
      if (a == REG_ID)
         rd_byte = ID_CODE;
      else if (a == REG_STATUS)
         rd_byte = {5'h00, busy_q, ready_q, done_q};
      else if (a == REG_ADC_CFG)
         rd_byte = cfg_q;
      else if (a[5:2] == REG_SAMPLE_BASE[5:2])
         rd_byte = samp_q[a[1:0]];
      else if (a[5:4] == REG_RESULT_BASE[5:4])
         rd_byte = a[0] ? {6'h00, res_q[slot][1:0]} : res_q[slot][9:2];
   endfunction

   // ==========================================================
   // serial port
   spi_state_t st_q;
   logic [2:0] bitc_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic       dir_q;
   logic       ai_q;
   logic [5:0] addr_q;
   logic       sdo_q;

   wire [7:0] rx_full   = {rx_q[6:0], sdi_w};
   wire       byte_done = sel_w & sclk_rise & (bitc_q == 3'd7);
   wire [5:0] hdr_addr  = {rx_full[6:3], rx_full[1:0]};
   wire [5:0] addr_next = addr_q + 6'd1;
   wire       reg_wr    = byte_done & (st_q == SP_DATA) & ~dir_q;
   wire       stat_clr  = reg_wr & (addr_q == REG_STATUS) & rx_full[STAT_DONE_BIT];

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_q   <= SP_HDR;
         bitc_q <= 3'd0;
         rx_q   <= 8'h00;
         tx_q   <= 8'h00;
         dir_q  <= 1'b0;
         ai_q   <= 1'b0;
         addr_q <= 6'h00;
         sdo_q  <= 1'b0;
      end else if (!sel_w) begin
         // a byte cut short by select falling is simply forgotten
         st_q   <= SP_HDR;
         bitc_q <= 3'd0;
         tx_q   <= 8'h00;
         sdo_q  <= 1'b0;
      end else begin
         if (sclk_rise) begin
            rx_q   <= rx_full;
            bitc_q <= bitc_q + 3'd1;
         end
         if (sclk_fall) begin
            sdo_q <= tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b0};
         end
         if (byte_done) begin
            case (st_q)
               SP_HDR: begin
                  dir_q  <= rx_full[HDR_DIR_BIT];
                  ai_q   <= rx_full[HDR_AI_BIT];
                  addr_q <= hdr_addr;
                  tx_q   <= rx_full[HDR_DIR_BIT] ? rd_byte(hdr_addr) : 8'h00;
                  st_q   <= SP_DATA;
               end
               SP_DATA: begin
                  addr_q <= addr_next;
                  tx_q   <= (dir_q & ai_q) ? rd_byte(addr_next) : 8'h00;
                  st_q   <= ai_q ? SP_DATA : SP_WAIT;
               end
               SP_WAIT: begin
                  st_q <= SP_WAIT;
               end
               default: begin
                  st_q <= SP_HDR;
               end
            endcase
         end
      end
   end

   assign LINK.serial_data_out = sdo_q;

   // ==========================================================
   // registers written over the serial port
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         cfg_q <= CFG_RESET;
         for (int i = 0; i < 4; i++) begin
            samp_q[i] <= SAMPLE_RESET;
         end
      end else if (reg_wr) begin
         if (addr_q == REG_ADC_CFG)
            cfg_q <= rx_full;
         else if (addr_q[5:2] == REG_SAMPLE_BASE[5:2])
            samp_q[addr_q[1:0]] <= rx_full;
      end
   end

   // ==========================================================
   // wake-up and conversion sequencer
   wire conv_start = en_w & ready_q & conv_on_q & ~busy_q & trig_rise;
   wire conv_end   = busy_q & (conv_cnt_q == CONV_CNT_W'(CONV_CYC - 1));

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         conv_on_q  <= 1'b0;
         ready_q    <= 1'b0;
         wake_q     <= '0;
         busy_q     <= 1'b0;
         conv_cnt_q <= '0;
         cnt_q      <= 3'd0;
      end else begin
         if (en_rise)
            conv_on_q <= cfg_q[CFG_CONV_EN_BIT];
         if (!en_w) begin
            ready_q <= 1'b0;
            wake_q  <= '0;
            busy_q  <= 1'b0;
            cnt_q   <= 3'd0;
         end else begin
            if (!ready_q) begin
               wake_q <= wake_q + 1'b1;
               if (wake_q == WAKE_CNT_W'(WAKE_CYC - 1))
                  ready_q <= 1'b1;
            end
            if (conv_start) begin
               busy_q     <= 1'b1;
               conv_cnt_q <= '0;
            end else if (busy_q) begin
               conv_cnt_q <= conv_cnt_q + 1'b1;
            end
            if (conv_end) begin
               busy_q <= 1'b0;
               cnt_q  <= cnt_q + 3'd1;
            end
         end
      end
   end

   // the done flag: a conversion ending wins over a clear in the same cycle
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN)
         done_q <= 1'b0;
      else
         done_q <= conv_end | (done_q & ~stat_clr & ~en_rise);
   end

   // result memory, wiped at each new enable interval
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         for (int i = 0; i < 8; i++) begin
            res_q[i] <= '0;
         end
      end else if (en_rise) begin
         for (int i = 0; i < 8; i++) begin
            res_q[i] <= '0;
         end
      end else if (conv_end) begin
         res_q[cnt_q] <= I_ADC_RESULT;
      end
   end

   // ==========================================================
   // selection and power outputs
   wire [7:0] samp_pair = samp_q[cnt_q[2:1]];
   wire [3:0] sel_field = cnt_q[0] ? samp_pair[7:4] : samp_pair[3:0];

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_PD_SELECT  <= 1'b0;
         O_MUX_SELECT <= 3'd0;
         O_SLEEP      <= 1'b1;
      end else begin
         O_PD_SELECT  <= sel_field[3];
         O_MUX_SELECT <= sel_field[2:0];
         O_SLEEP      <= ~en_w;
      end
   end

   assign O_CONVERTING             = busy_q;
   assign LINK.front_end_ready_pin = ready_q;

endmodule

// File: rtl/afe_host.sv
// controller end: serial master, enable and trigger pacing behind a register port
module afe_host (
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RSTN,
   input  wire logic [3:0]  I_ADDR,
   input  wire logic [7:0]  I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic [7:0]       O_RDATA,
   afe_link_if.host         LINK
);
   import afe_pkg::*;

   // ==========================================================
   // pin synchronisers and registers
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [7:0] hdr_q;
   logic [2:0] len_q;
   logic [7:0] buf_q [8];
   logic       en_q;
   logic       trig_q;
   logic [HOST_CNT_W-1:0] trig_cnt_q;
   logic [HOST_CNT_W-1:0] hold_cnt_q;

   host_state_t st_q;
   logic [3:0]  ph_q;
   logic [2:0]  bit_q;
   logic [3:0]  byte_q;
   logic [7:0]  tx_q;
   logic [7:0]  rx_q;
   logic        sclk_q;
   logic        sel_q;

   wire sdo_w    = pin_s2_q[0];
   wire ready_w  = pin_s2_q[1];
   wire busy_w   = (st_q != HS_IDLE);
   wire wr_ctrl  = I_WR & (I_ADDR == HREG_CTRL);
   // serial traffic is held off while the front end is awake or woken by the same write
   wire start_w  = wr_ctrl & I_WDATA[CTRL_START_BIT] & ~I_WDATA[CTRL_ENABLE_BIT]
                   & ~busy_w & ~en_q;
   wire trig_ok  = en_q & ready_w & (trig_cnt_q == '0);
   // a trigger in a write that also drops enable would reach a sleeping front end
   wire trig_go  = wr_ctrl & I_WDATA[CTRL_TRIG_BIT] & I_WDATA[CTRL_ENABLE_BIT] & trig_ok;
   wire en_want  = wr_ctrl & I_WDATA[CTRL_ENABLE_BIT];
   wire en_drop  = wr_ctrl & ~I_WDATA[CTRL_ENABLE_BIT] & (hold_cnt_q == '0);
   wire [7:0] stat_w = {4'h0, (trig_cnt_q != '0), ready_w, en_q, busy_w};

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pin_s1_q <= 2'b00;
         pin_s2_q <= 2'b00;
      end else begin
         pin_s1_q <= {LINK.front_end_ready_pin, LINK.serial_data_out};
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_RDATA <= 8'h00;
         hdr_q   <= 8'h00;
         len_q   <= 3'd0;
      end else begin
         O_RDATA <= 8'h00;
         if (I_RD) begin
            if (I_ADDR == HREG_HEADER)
               O_RDATA <= hdr_q;
            else if (I_ADDR == HREG_CTRL)
               O_RDATA <= stat_w;
            else if (I_ADDR == HREG_LEN)
               O_RDATA <= {5'h00, len_q};
            else if (I_ADDR[3])
               O_RDATA <= buf_q[I_ADDR[2:0]];
         end
         if (I_WR & ~busy_w & (I_ADDR == HREG_HEADER))
            hdr_q <= I_WDATA;
         if (I_WR & ~busy_w & (I_ADDR == HREG_LEN))
            len_q <= I_WDATA[2:0];
      end
   end

   // ==========================================================
   // enable and trigger pacing
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         en_q       <= 1'b0;
         trig_q     <= 1'b0;
         trig_cnt_q <= '0;
         hold_cnt_q <= '0;
      end else begin
         if (en_want & ~busy_w)
            en_q <= 1'b1;
         else if (en_drop)
            en_q <= 1'b0;
         if (trig_go) begin
            trig_q     <= 1'b1;
            trig_cnt_q <= HOST_CNT_W'(TRIG_SPACE_CYC - 1);
            // the front end sees our trigger edge only after its synchroniser
            hold_cnt_q <= HOST_CNT_W'(HOLD_CYC + SYNC_CYC - 1);
         end else begin
            if (trig_cnt_q != '0)
               trig_cnt_q <= trig_cnt_q - 1'b1;
            if (hold_cnt_q != '0)
               hold_cnt_q <= hold_cnt_q - 1'b1;
            if (trig_cnt_q == HOST_CNT_W'(TRIG_SPACE_CYC - TRIG_HIGH_CYC))
               trig_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // serial master: clock idles low, data leaves on the fall
   wire       last_ph  = (ph_q == 4'(2 * SCLK_HALF_CYC - 1));
   wire       last_bit = (bit_q == 3'd7) & (byte_q == {1'b0, len_q} + 4'd1);
   wire [3:0] byte_nx  = byte_q + 4'd1;

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_q   <= HS_IDLE;
         ph_q   <= 4'd0;
         bit_q  <= 3'd0;
         byte_q <= 4'd0;
         tx_q   <= 8'h00;
         rx_q   <= 8'h00;
         sclk_q <= 1'b0;
         sel_q  <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else begin
         case (st_q)
            HS_IDLE: begin
               if (I_WR & ~busy_w & I_ADDR[3])
                  buf_q[I_ADDR[2:0]] <= I_WDATA;
               if (start_w) begin
                  sel_q  <= 1'b1;
                  tx_q   <= hdr_q;
                  ph_q   <= 4'd0;
                  bit_q  <= 3'd0;
                  byte_q <= 4'd0;
                  st_q   <= HS_SHIFT;
               end
            end
            HS_SHIFT: begin
               ph_q <= ph_q + 4'd1;
               if (ph_q == 4'(SCLK_HALF_CYC - 1)) begin
                  sclk_q <= 1'b1;
                  rx_q   <= {rx_q[6:0], sdo_w};
               end
               if (last_ph) begin
                  sclk_q <= 1'b0;
                  ph_q   <= 4'd0;
                  bit_q  <= bit_q + 3'd1;
                  tx_q   <= {tx_q[6:0], 1'b0};
                  if (bit_q == 3'd7) begin
                     byte_q <= byte_nx;
                     tx_q   <= buf_q[byte_q[2:0]];
                     if ((byte_q != 4'd0) & hdr_q[HDR_DIR_BIT])
                        buf_q[byte_q[2:0] - 3'd1] <= rx_q;
                  end
                  if (last_bit)
                     st_q <= HS_LAG;
               end
            end
            HS_LAG: begin
               ph_q <= ph_q + 4'd1;
               if (ph_q == 4'(SCLK_HALF_CYC - 1)) begin
                  sel_q <= 1'b0;
                  st_q  <= HS_IDLE;
               end
            end
            default: begin
               st_q <= HS_IDLE;
            end
         endcase
      end
   end

   assign LINK.serial_select          = sel_q;
   assign LINK.serial_clock           = sclk_q;
   assign LINK.serial_data_in         = tx_q[7];
   assign LINK.front_end_enable_pin   = en_q;
   assign LINK.conversion_trigger_pin = trig_q;

endmodule

// File: rtl/afe_link_if.sv
// pins between the front end and its controller
interface afe_link_if;
   logic serial_select;
   logic serial_clock;
   logic serial_data_in;
   logic serial_data_out;
   logic front_end_enable_pin;
   logic front_end_ready_pin;
   logic conversion_trigger_pin;

   modport dev (
      input  serial_select,
      input  serial_clock,
      input  serial_data_in,
      output serial_data_out,
      input  front_end_enable_pin,
      output front_end_ready_pin,
      input  conversion_trigger_pin
   );

   modport host (
      output serial_select,
      output serial_clock,
      output serial_data_in,
      input  serial_data_out,
      output front_end_enable_pin,
      input  front_end_ready_pin,
      output conversion_trigger_pin
   );
endinterface

// File: rtl/afe_pkg.sv
// shared constants and types for the front-end serial port and sample sequencer
package afe_pkg;

   // ==========================================================
   // timing
   localparam int CLK_NS            = 100;
   localparam int SYNC_CYC          = 3;
   localparam int WAKE_MAX_NS       = 50000;
   localparam int WAKE_CYC          = WAKE_MAX_NS / CLK_NS - SYNC_CYC;
   localparam int WAKE_CNT_W        = 9;
   localparam int CONV_MAX_NS       = 10000;
   localparam int CONV_CYC          = CONV_MAX_NS / CLK_NS;
   localparam int CONV_CNT_W        = 7;
   localparam int TRIG_HIGH_MIN_NS  = 1000;
   localparam int TRIG_HIGH_CYC     = (TRIG_HIGH_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRIG_SPACE_MIN_NS = 10000;
   localparam int TRIG_SPACE_CYC    = (TRIG_SPACE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int DROP_MIN_NS       = 1000;
   localparam int DROP_CYC          = (DROP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC          = TRIG_SPACE_CYC + DROP_CYC;
   localparam int HOST_CNT_W        = 8;
   localparam int SCLK_HALF_NS      = 800;
   localparam int SCLK_HALF_CYC     = SCLK_HALF_NS / CLK_NS;

   // ==========================================================
   // device register map
   localparam int          RESULT_W        = 10;
   localparam logic [5:0]  REG_ID          = 6'h00;
   localparam logic [5:0]  REG_STATUS      = 6'h09;
   localparam logic [5:0]  REG_ADC_CFG     = 6'h0b;
   localparam logic [5:0]  REG_SAMPLE_BASE = 6'h0c;
   localparam logic [5:0]  REG_RESULT_BASE = 6'h10;
   localparam int          STAT_DONE_BIT   = 0;
   localparam int          STAT_READY_BIT  = 1;
   localparam int          STAT_BUSY_BIT   = 2;
   localparam int          CFG_CONV_EN_BIT = 0;
   localparam logic [7:0]  CFG_RESET       = 8'h01;
   localparam logic [7:0]  SAMPLE_RESET    = 8'h00;
   localparam int          HDR_DIR_BIT     = 7;
   localparam int          HDR_AI_BIT      = 2;

   // ==========================================================
   // controller register map
   localparam logic [3:0]  HREG_HEADER     = 4'h0;
   localparam logic [3:0]  HREG_CTRL       = 4'h1;
   localparam logic [3:0]  HREG_LEN        = 4'h2;
   localparam int          CTRL_START_BIT  = 0;
   localparam int          CTRL_ENABLE_BIT = 1;
   localparam int          CTRL_TRIG_BIT   = 2;
   localparam int          HST_BUSY_BIT    = 0;
   localparam int          HST_ENABLE_BIT  = 1;
   localparam int          HST_READY_BIT   = 2;
   localparam int          HST_TRIG_BIT    = 3;

   typedef enum logic [2:0] {
      SP_HDR  = 3'b001,
      SP_DATA = 3'b010,
      SP_WAIT = 3'b100
   } spi_state_t;

   typedef enum logic [2:0] {
      HS_IDLE  = 3'b001,
      HS_SHIFT = 3'b010,
      HS_LAG   = 3'b100
   } host_state_t;

endpackage
